// [hw/sfc_device.sv]
// Device end of the frame codec: host byte link to radio engine.
// Assumes radio fields steady while rrx_valid; mode may come from pins.
`timescale 1ns/1ps
`default_nettype none
module sfc_device (
  input wire logic ref_clk,
  input wire logic reset_n,
  sfc_link_if.dev link,
  input wire logic [1:0] api_mode_select,
  output logic [7:0] rtx_data,
  output logic rtx_last,
  output logic rtx_valid,
  input wire logic rtx_ready,
  output logic [15:0] rtx_dest,
  output logic [7:0] rtx_opt,
  input wire logic radio_txdone,
  input wire logic radio_noack,
  input wire logic radio_purged,
  input wire logic mstat_valid,
  input wire logic [7:0] mstat_code,
  input wire logic [7:0] rrx_data,
  input wire logic rrx_valid,
  input wire logic rrx_last,
  output logic rrx_ready,
  input wire logic [15:0] rrx_len,
  input wire logic [15:0] rrx_src,
  input wire logic [7:0] rrx_rssi,
  input wire logic [7:0] rrx_opt
);
  typedef struct packed {
    logic [1:0] msync1, msync2;
    sfc_pkg::sfc_parse_e ps;
    logic esc;
    logic [15:0] len, idx;
    logic [7:0] sum, typ, fid;
    logic [15:0] dest;
    logic [7:0] opt;
    logic ovf;
    logic [7:0] q_fid;
    logic [15:0] q_dest;
    logic [7:0] q_opt;
    logic [15:0] dcnt;
    logic [7:0] rd;
    logic h2d_rdy;
    logic [7:0] e0, e1;
    logic l0, l1, v0, v1, ts_pend;
    logic [7:0] ts_fid, ts_code;
    logic ms_pend;
    logic [7:0] ms_code;
    logic fact, tp;
    logic [15:0] fidx, flen;
    logic [2:0] fh;
    logic [4:0][7:0] fhdr;
    logic [7:0] fsum;
    logic rrx_rdy;
    logic [7:0] cb;
    logic cv, craw, ep;
    logic [7:0] eb;
    logic [7:0] od;
    logic ov;
  } sfc_dev_s;

  sfc_dev_s s;
  sfc_dev_s n;
  logic [7:0] pay_mem [0:sfc_pkg::PAY_DEPTH-1];
  logic mem_we;
  logic [sfc_pkg::PAY_AW-1:0] mem_wa;
  logic [7:0] mem_wd;
  logic [1:0] mode;
  logic framed, take_h, take_rx, push, push_last;
  logic [7:0] push_d, ub;
  logic [15:0] pidx, di;

  // True while the framer waits on radio payload bytes
  function automatic logic pay_ph(input logic act, input logic tp, input logic [15:0] idx,
    input logic [15:0] flen, input logic [2:0] hl);
    return act && (tp || (idx >= sfc_pkg::FRAME_OVH + {13'h0, hl}
      && idx < sfc_pkg::FRAME_OVH + flen));
  endfunction : pay_ph

  // Next-state logic for parser, payload drain, buffer and framer
  always_comb begin
    n = s;
    n.msync1 = api_mode_select;
    n.msync2 = s.msync1;
    mode = s.msync2;
    framed = (mode == sfc_pkg::MODE_API) || (mode == sfc_pkg::MODE_ESC);
    take_h = link.h2d_valid && s.h2d_rdy;
    take_rx = rrx_valid && s.rrx_rdy;
    push = 1'b0;
    push_last = 1'b0;
    push_d = link.h2d_data;
    ub = s.esc ? (link.h2d_data ^ sfc_pkg::ESC_XOR) : link.h2d_data;
    pidx = s.idx - sfc_pkg::TXREQ_HDR;
    di = s.fidx - sfc_pkg::FRAME_OVH;
    mem_we = 1'b0;
    mem_wa = pidx[sfc_pkg::PAY_AW-1:0];
    mem_wd = ub;

    // Two-entry buffer toward the radio; pop first so a push always fits
    if (s.v0 && rtx_ready) begin
      n.e0 = s.e1;
      n.l0 = s.l1;
      n.v0 = s.v1;
      n.v1 = 1'b0;
    end

    // Host-to-device parser
    if (!framed && s.ps != sfc_pkg::P_DRAIN) begin
      n.ps = sfc_pkg::P_HUNT;
      n.esc = 1'b0;
      push = take_h;
    end else if (take_h) begin
      if (mode == sfc_pkg::MODE_ESC && link.h2d_data == sfc_pkg::ESC_BYTE
          && s.ps != sfc_pkg::P_HUNT) begin
        n.esc = 1'b1;
      end else if (link.h2d_data == sfc_pkg::DELIM
          && (s.ps == sfc_pkg::P_HUNT || mode == sfc_pkg::MODE_ESC)) begin
        n.ps = sfc_pkg::P_LENH;
        n.esc = 1'b0;
      end else begin
        n.esc = 1'b0;
        case (s.ps)
          sfc_pkg::P_LENH: begin
            n.len[15:8] = ub;
            n.ps = sfc_pkg::P_LENL;
          end
          sfc_pkg::P_LENL: begin
            n.len[7:0] = ub;
            n.idx = 16'h0000;
            n.sum = 8'h00;
            n.ovf = 1'b0;
            n.ps = ({s.len[15:8], ub} == 16'h0000) ? sfc_pkg::P_HUNT : sfc_pkg::P_DATA;
          end
          sfc_pkg::P_DATA: begin
            n.sum = s.sum + ub;
            n.idx = s.idx + 16'h0001;
            case (s.idx)
              16'h0000: n.typ = ub;
              16'h0001: n.fid = ub;
              16'h0002: n.dest[15:8] = ub;
              16'h0003: n.dest[7:0] = ub;
              16'h0004: n.opt = ub;
              default: begin
                mem_we = (pidx[15:sfc_pkg::PAY_AW] == '0);
                n.ovf = s.ovf || !mem_we;
              end
            endcase
            if (s.idx + 16'h0001 == s.len) begin
              n.ps = sfc_pkg::P_CSUM;
            end
          end
          sfc_pkg::P_CSUM: begin
            if (s.sum + ub == sfc_pkg::SUM_OK && s.typ == sfc_pkg::ID_TXREQ
                && s.len > sfc_pkg::TXREQ_HDR && !s.ovf) begin
              n.q_fid = s.fid;
              n.q_dest = s.dest;
              n.q_opt = s.opt;
              n.rd = 8'h00;
              n.dcnt = s.len - sfc_pkg::TXREQ_HDR;
              n.ps = sfc_pkg::P_DRAIN;
            end else begin
              n.ps = sfc_pkg::P_HUNT;
            end
          end
          default: n.ps = sfc_pkg::P_HUNT;
        endcase
      end
    end

    // Hand a checked payload to the radio, one byte per free slot
    if (s.ps == sfc_pkg::P_DRAIN && !s.v1) begin
      push = 1'b1;
      push_d = pay_mem[s.rd];
      push_last = ({8'h00, s.rd} == s.dcnt - 16'h0001);
      n.rd = s.rd + 8'h01;
      if (push_last) begin
        n.ps = sfc_pkg::P_HUNT;
      end
    end
    if (push) begin
      if (!n.v0) begin
        n.e0 = push_d;
        n.l0 = push_last;
        n.v0 = 1'b1;
      end else begin
        n.e1 = push_d;
        n.l1 = push_last;
        n.v1 = 1'b1;
      end
    end
    // Host is held off while draining so the payload store is never overwritten
    n.h2d_rdy = (n.ps != sfc_pkg::P_DRAIN) && (framed || !n.v1);

    // Output stage: escape insertion toward the host
    if (!s.ov || link.d2h_ready) begin
      n.ov = 1'b0;
      if (s.ep) begin
        n.od = s.eb;
        n.ov = 1'b1;
        n.ep = 1'b0;
      end else if (s.cv) begin
        n.cv = 1'b0;
        n.ov = 1'b1;
        n.od = s.cb;
        if (mode == sfc_pkg::MODE_ESC && !s.craw && sfc_pkg::sfc_needs_esc(s.cb)) begin
          n.od = sfc_pkg::ESC_BYTE;
          n.ep = 1'b1;
          n.eb = s.cb ^ sfc_pkg::ESC_XOR;
        end
      end
    end

    // Framer: pick a source, then produce one raw byte per free slot
    if (!n.cv) begin
      if (!s.fact) begin
        n.fidx = 16'h0000;
        n.fsum = 8'h00;
        n.tp = 1'b0;
        if (!framed) begin
          n.fact = rrx_valid;
          n.tp = 1'b1;
        end else if (s.ts_pend) begin
          n.fact = 1'b1;
          n.ts_pend = 1'b0;
          n.fh = sfc_pkg::TXSTAT_HDR;
          n.flen = {13'h0, sfc_pkg::TXSTAT_HDR};
          n.fhdr = {16'h0000, s.ts_code, s.ts_fid, sfc_pkg::ID_TXSTAT};
        end else if (s.ms_pend) begin
          n.fact = 1'b1;
          n.ms_pend = 1'b0;
          n.fh = sfc_pkg::MSTAT_HDR;
          n.flen = {13'h0, sfc_pkg::MSTAT_HDR};
          n.fhdr = {24'h000000, s.ms_code, sfc_pkg::ID_MSTAT};
        end else if (rrx_valid) begin
          n.fact = 1'b1;
          n.fh = sfc_pkg::RXPKT_HDR;
          n.flen = {13'h0, sfc_pkg::RXPKT_HDR} + rrx_len;
          n.fhdr = {rrx_opt, rrx_rssi, rrx_src[7:0], rrx_src[15:8], sfc_pkg::ID_RXPKT};
        end
      end else if (pay_ph(s.fact, s.tp, s.fidx, s.flen, s.fh)) begin
        if (take_rx) begin
          n.cb = rrx_data;
          n.cv = 1'b1;
          n.craw = s.tp;
          n.fsum = s.fsum + rrx_data;
          n.fidx = s.fidx + 16'h0001;
          n.fact = !(s.tp && rrx_last);
        end
      end else begin
        n.cv = 1'b1;
        n.craw = 1'b0;
        n.fidx = s.fidx + 16'h0001;
        if (s.fidx == 16'h0000) begin
          n.cb = sfc_pkg::DELIM;
          n.craw = 1'b1;
        end else if (s.fidx == 16'h0001) begin
          n.cb = s.flen[15:8];
        end else if (s.fidx == 16'h0002) begin
          n.cb = s.flen[7:0];
        end else if (s.fidx == sfc_pkg::FRAME_OVH + s.flen) begin
          n.cb = sfc_pkg::SUM_OK - s.fsum;
          n.fact = 1'b0;
        end else begin
          n.cb = s.fhdr[di[2:0]];
          n.fsum = s.fsum + s.fhdr[di[2:0]];
        end
      end
    end
    n.rrx_rdy = pay_ph(n.fact, n.tp, n.fidx, n.flen, n.fh) && !n.cv;

    // Event capture after the framer so a new event beats a same-cycle clear
    if (radio_txdone && framed) begin
      n.ts_pend = 1'b1;
      n.ts_fid = s.q_fid;
      n.ts_code = radio_purged ? sfc_pkg::ST_PURGED
          : radio_noack ? sfc_pkg::ST_NOACK : sfc_pkg::ST_OK;
    end
    if (mstat_valid && framed) begin
      n.ms_pend = 1'b1;
      n.ms_code = mstat_code;
    end
  end

  // State register; reset leaves everything idle and not ready
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  // Payload store; held back until the checksum has passed
  always_ff @(posedge ref_clk) begin
    if (mem_we) begin
      pay_mem[mem_wa] <= mem_wd;
    end
  end

  assign link.h2d_ready = s.h2d_rdy;
  assign link.d2h_data = s.od;
  assign link.d2h_valid = s.ov;
  assign rtx_data = s.e0;
  assign rtx_last = s.l0;
  assign rtx_valid = s.v0;
  assign rtx_dest = s.q_dest;
  assign rtx_opt = s.q_opt;
  assign rrx_ready = s.rrx_rdy;
endmodule : sfc_device
`default_nettype wire

// [hw/sfc_pkg.sv]
// Shared constants and types of the serial frame codec.
// Assumes both ends run on ref_clk and meet through sfc_link_if.
package sfc_pkg;
  localparam logic [1:0] MODE_TRANSP = 2'h0; // Reset value of the mode pins
  localparam logic [1:0] MODE_API = 2'h1;
  localparam logic [1:0] MODE_ESC = 2'h2; // Value 3 is treated as transparent
  localparam logic [7:0] DELIM = 8'h7e;
  localparam logic [7:0] ESC_BYTE = 8'h7d;
  localparam logic [7:0] ESC_XOR = 8'h20;
  localparam logic [7:0] XON = 8'h11;
  localparam logic [7:0] XOFF = 8'h13;
  localparam logic [7:0] SUM_OK = 8'hff;
  localparam logic [7:0] ID_TXREQ = 8'h01;
  localparam logic [7:0] ID_RXPKT = 8'h81;
  localparam logic [7:0] ID_TXSTAT = 8'h89;
  localparam logic [7:0] ID_MSTAT = 8'h8a;
  localparam logic [7:0] ST_OK = 8'h00;
  localparam logic [7:0] ST_NOACK = 8'h01;
  localparam logic [7:0] ST_PURGED = 8'h03;
  localparam logic [15:0] TXREQ_HDR = 16'h0005; // Id, frame id, address, option
  localparam logic [2:0] RXPKT_HDR = 3'h5; // Id, source address, signal, option
  localparam logic [2:0] TXSTAT_HDR = 3'h3; // Id, frame id, status
  localparam logic [2:0] MSTAT_HDR = 3'h2; // Id, status
  localparam logic [15:0] FRAME_OVH = 16'h0003; // Delimiter and two length bytes
  localparam int PAY_DEPTH = 256;
  localparam int PAY_AW = 8;

  typedef enum logic [2:0] {
    P_HUNT = 3'b000,
    P_LENH = 3'b001,
    P_LENL = 3'b010,
    P_DATA = 3'b011,
    P_CSUM = 3'b100,
    P_DRAIN = 3'b101
  } sfc_parse_e;

  // Bytes that may not appear bare inside an escaped frame
  function automatic logic sfc_needs_esc(input logic [7:0] b);
    return (b == DELIM) || (b == ESC_BYTE) || (b == XON) || (b == XOFF);
  endfunction : sfc_needs_esc
endpackage : sfc_pkg

// [hw/sfc_link_if.sv]
// Byte link between host and device ends, valid/ready per direction.
// Assumes both ends sit on the same clock; the bench joins the modports.
`timescale 1ns/1ps
`default_nettype none
interface sfc_link_if;
  logic [7:0] h2d_data;
  logic h2d_valid;
  logic h2d_ready;
  logic [7:0] d2h_data;
  logic d2h_valid;
  logic d2h_ready;
  modport dev (input h2d_data, h2d_valid, d2h_ready, output h2d_ready, d2h_data, d2h_valid);
  modport host (output h2d_data, h2d_valid, d2h_ready, input h2d_ready, d2h_data, d2h_valid);
endinterface : sfc_link_if
`default_nettype wire

// [hw/sfc_host.sv]
// Host end of the frame codec: frames user data, checks device frames.
// Assumes the user holds tx_len steady for a whole frame.
`timescale 1ns/1ps
`default_nettype none
module sfc_host (
  input wire logic ref_clk,
  input wire logic reset_n,
  sfc_link_if.host link,
  input wire logic [1:0] api_mode_select,
  input wire logic [15:0] tx_len,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic rx_end,
  output logic rx_ok
);
  typedef struct packed {
    logic [1:0] msync1, msync2;
    sfc_pkg::sfc_parse_e ps;
    logic esc;
    logic [15:0] len, idx;
    logic [7:0] sum, rxd;
    logic rxv, rxe, rxk, d2h_rdy, fact;
    logic [15:0] fidx, flen;
    logic [7:0] fsum;
    logic trdy;
    logic [7:0] cb;
    logic cv, craw, ep;
    logic [7:0] eb;
    logic [7:0] od;
    logic ov;
  } sfc_host_s;

  sfc_host_s s;
  sfc_host_s n;
  logic [1:0] mode;
  logic framed, take_d, take_u;
  logic [7:0] ub;

  // True while the framer takes user bytes
  function automatic logic pay_ph(input logic act, input logic tp, input logic [15:0] idx,
    input logic [15:0] flen);
    return act && (tp || (idx >= sfc_pkg::FRAME_OVH && idx < sfc_pkg::FRAME_OVH + flen));
  endfunction : pay_ph

  // Next-state logic for receive parser and send framer
  always_comb begin
    n = s;
    n.msync1 = api_mode_select;
    n.msync2 = s.msync1;
    mode = s.msync2;
    framed = (mode == sfc_pkg::MODE_API) || (mode == sfc_pkg::MODE_ESC);
    take_d = link.d2h_valid && s.d2h_rdy;
    take_u = tx_valid && s.trdy;
    ub = s.esc ? (link.d2h_data ^ sfc_pkg::ESC_XOR) : link.d2h_data;
    n.d2h_rdy = 1'b1; // Host never stalls the device
    n.rxv = 1'b0;
    n.rxe = 1'b0;

    // Receive parser; a broken frame ends with rx_ok low
    if (!framed) begin
      n.ps = sfc_pkg::P_HUNT;
      n.rxd = link.d2h_data;
      n.rxv = take_d;
    end else if (take_d) begin
      if (mode == sfc_pkg::MODE_ESC && link.d2h_data == sfc_pkg::ESC_BYTE
          && s.ps != sfc_pkg::P_HUNT) begin
        n.esc = 1'b1;
      end else if (link.d2h_data == sfc_pkg::DELIM
          && (s.ps == sfc_pkg::P_HUNT || mode == sfc_pkg::MODE_ESC)) begin
        n.ps = sfc_pkg::P_LENH;
        n.esc = 1'b0;
        n.rxe = (s.ps == sfc_pkg::P_DATA) || (s.ps == sfc_pkg::P_CSUM);
        n.rxk = 1'b0;
      end else begin
        n.esc = 1'b0;
        case (s.ps)
          sfc_pkg::P_LENH: begin
            n.len[15:8] = ub;
            n.ps = sfc_pkg::P_LENL;
          end
          sfc_pkg::P_LENL: begin
            n.len[7:0] = ub;
            n.idx = 16'h0000;
            n.sum = 8'h00;
            n.ps = ({s.len[15:8], ub} == 16'h0000) ? sfc_pkg::P_HUNT : sfc_pkg::P_DATA;
          end
          sfc_pkg::P_DATA: begin
            n.sum = s.sum + ub;
            n.idx = s.idx + 16'h0001;
            n.rxd = ub;
            n.rxv = 1'b1;
            if (s.idx + 16'h0001 == s.len) begin
              n.ps = sfc_pkg::P_CSUM;
            end
          end
          sfc_pkg::P_CSUM: begin
            n.rxe = 1'b1;
            n.rxk = (s.sum + ub == sfc_pkg::SUM_OK);
            n.ps = sfc_pkg::P_HUNT;
          end
          default: n.ps = sfc_pkg::P_HUNT;
        endcase
      end
    end

    // Output stage with escape insertion
    if (!s.ov || link.h2d_ready) begin
      n.ov = 1'b0;
      if (s.ep) begin
        n.od = s.eb;
        n.ov = 1'b1;
        n.ep = 1'b0;
      end else if (s.cv) begin
        n.cv = 1'b0;
        n.ov = 1'b1;
        n.od = s.cb;
        if (mode == sfc_pkg::MODE_ESC && !s.craw && sfc_pkg::sfc_needs_esc(s.cb)) begin
          n.od = sfc_pkg::ESC_BYTE;
          n.ep = 1'b1;
          n.eb = s.cb ^ sfc_pkg::ESC_XOR;
        end
      end
    end

    // Send framer: delimiter, length, user frame data, checksum
    if (!n.cv) begin
      if (!s.fact) begin
        n.fact = tx_valid;
        n.fidx = 16'h0000;
        n.fsum = 8'h00;
        n.flen = tx_len;
      end else if (pay_ph(s.fact, !framed, s.fidx, s.flen)) begin
        if (take_u) begin
          n.cb = tx_data;
          n.cv = 1'b1;
          n.craw = !framed;
          n.fsum = s.fsum + tx_data;
          n.fidx = s.fidx + 16'h0001;
          n.fact = framed;
        end
      end else begin
        n.cv = 1'b1;
        n.craw = (s.fidx == 16'h0000);
        n.fidx = s.fidx + 16'h0001;
        if (s.fidx == 16'h0000) begin
          n.cb = sfc_pkg::DELIM;
        end else if (s.fidx == 16'h0001) begin
          n.cb = s.flen[15:8];
        end else if (s.fidx == 16'h0002) begin
          n.cb = s.flen[7:0];
        end else begin
          n.cb = sfc_pkg::SUM_OK - s.fsum;
          n.fact = 1'b0;
        end
      end
    end
    n.trdy = pay_ph(n.fact, !framed, n.fidx, n.flen) && !n.cv;
  end

  // State register
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign link.h2d_data = s.od;
  assign link.h2d_valid = s.ov;
  assign link.d2h_ready = s.d2h_rdy;
  assign tx_ready = s.trdy;
  assign rx_data = s.rxd;
  assign rx_valid = s.rxv;
  assign rx_end = s.rxe;
  assign rx_ok = s.rxk;
endmodule : sfc_host
`default_nettype wire

// [test/sfc_link_properties.sv]
// Link handshake and escape checks.
// Assumes one clock; the bench instantiates it beside the link.
`timescale 1ns/1ps
`default_nettype none
module sfc_link_properties (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [7:0] h2d_data,
  input wire logic h2d_valid,
  input wire logic h2d_ready,
  input wire logic [7:0] d2h_data,
  input wire logic d2h_valid,
  input wire logic d2h_ready
);
  logic h_esc_ff;
  logic d_esc_ff;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // Remember a taken escape byte
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      h_esc_ff <= 1'b0;
      d_esc_ff <= 1'b0;
    end else begin
      if (h2d_valid && h2d_ready) h_esc_ff <= h2d_data == 8'h7d;
      if (d2h_valid && d2h_ready) d_esc_ff <= d2h_data == 8'h7d;
    end
  end
  // Offered bytes hold until taken
  property p_h2d_hold;
    h2d_valid && !h2d_ready |=> h2d_valid;
  endproperty
  a_h2d_hold: assert property (p_h2d_hold) else $error("h2d valid dropped");
  property p_h2d_stable;
    h2d_valid && !h2d_ready |=> $stable(h2d_data);
  endproperty
  a_h2d_stable: assert property (p_h2d_stable) else $error("h2d data moved");
  property p_d2h_hold;
    d2h_valid && !d2h_ready |=> d2h_valid;
  endproperty
  a_d2h_hold: assert property (p_d2h_hold) else $error("d2h valid dropped");
  property p_d2h_stable;
    d2h_valid && $past(d2h_valid && !d2h_ready) |-> $stable(d2h_data);
  endproperty
  a_d2h_stable: assert property (p_d2h_stable) else $error("d2h data moved");
  // Byte after an escape is a flipped escaped-set member
  property p_h2d_esc;
    h2d_valid && h2d_ready && h_esc_ff |-> (h2d_data ^ 8'h20) inside {8'h7e, 8'h7d, 8'h11, 8'h13};
  endproperty
  a_h2d_esc: assert property (p_h2d_esc) else $error("h2d bad escape");
  property p_d2h_esc;
    d2h_valid && d2h_ready && d_esc_ff |-> (d2h_data ^ 8'h20) inside {8'h7e, 8'h7d, 8'h11, 8'h13};
  endproperty
  a_d2h_esc: assert property (p_d2h_esc) else $error("d2h bad escape");
  // Flow bytes never cross bare; bench traffic avoids them raw
  property p_h2d_bare;
    h2d_valid && h2d_ready |-> !(h2d_data inside {8'h11, 8'h13});
  endproperty
  a_h2d_bare: assert property (p_h2d_bare) else $error("h2d bare flow byte");
  property p_d2h_bare;
    d2h_valid && d2h_ready |-> !(d2h_data inside {8'h11, 8'h13});
  endproperty
  a_d2h_bare: assert property (p_d2h_bare) else $error("d2h bare flow byte");
endmodule : sfc_link_properties
`default_nettype wire

// [test/serial_api_frame_codec_tb_top.sv]
// Bench: host and device ends on one link, plus a hand-fed device end.
// Needs sfc_pkg, both ends and the link interface.
`timescale 1ns/1ps
`default_nettype none
module serial_api_frame_codec_tb_top;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [1:0] mode = 2'h0;
  logic [15:0] tx_len = 16'h0;
  logic [7:0] tx_data = 8'h0;
  logic tx_valid = 1'b0;
  logic tx_ready, rx_valid, rx_end, rx_ok, rtx_last, rtx_valid, r2_valid, rrx_ready;
  logic [7:0] rx_data, rtx_data, r2_data, rtx_opt;
  logic [15:0] rtx_dest;
  logic rtx_ready = 1'b0, hold = 1'b0, radio_txdone = 1'b0, radio_noack = 1'b0;
  logic radio_purged = 1'b0, mstat_valid = 1'b0, rrx_valid = 1'b0, rrx_last = 1'b0;
  logic [7:0] mstat_code = 8'h0, rrx_data = 8'h0, rrx_rssi = 8'h28, rrx_opt = 8'h02;
  logic [15:0] rrx_len = 16'h0, rrx_src = 16'h4321;
  logic [9:0] rtx_q[$], e;
  logic [7:0] r2_q[$], rx_q[$], hq[$], wq[$], b[$], f[$];
  logic ok_q[$];
  logic [7:0] st[3] = '{8'h01, 8'h03, 8'h00};
  logic [3:0] evv[3] = '{4'h5, 4'h7, 4'h4};
  int n_fail = 0;
  int check_count = 0;
  sfc_link_if link();
  sfc_link_if link2();
  sfc_host sfc_host_inst (.ref_clk(ref_clk), .reset_n(reset_n), .link(link.host),
    .api_mode_select(mode), .tx_len(tx_len), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid), .rx_end(rx_end), .rx_ok(rx_ok));
  sfc_device sfc_device_inst (.ref_clk(ref_clk), .reset_n(reset_n), .link(link.dev),
    .api_mode_select(mode), .rtx_data(rtx_data), .rtx_last(rtx_last), .rtx_valid(rtx_valid),
    .rtx_ready(rtx_ready), .rtx_dest(rtx_dest), .rtx_opt(rtx_opt), .radio_txdone(radio_txdone),
    .radio_noack(radio_noack), .radio_purged(radio_purged), .mstat_valid(mstat_valid),
    .mstat_code(mstat_code), .rrx_data(rrx_data), .rrx_valid(rrx_valid), .rrx_last(rrx_last),
    .rrx_ready(rrx_ready), .rrx_len(rrx_len), .rrx_src(rrx_src), .rrx_rssi(rrx_rssi),
    .rrx_opt(rrx_opt));
  sfc_device sfc_device_inst2 (.ref_clk(ref_clk), .reset_n(reset_n), .link(link2.dev),
    .api_mode_select(mode), .rtx_data(r2_data), .rtx_last(), .rtx_valid(r2_valid),
    .rtx_ready(1'b1), .rtx_dest(), .rtx_opt(), .radio_txdone(radio_txdone),
    .radio_noack(radio_noack), .radio_purged(radio_purged), .mstat_valid(mstat_valid),
    .mstat_code(mstat_code), .rrx_data(rrx_data), .rrx_valid(rrx_valid), .rrx_last(rrx_last),
    .rrx_ready(), .rrx_len(rrx_len), .rrx_src(rrx_src), .rrx_rssi(rrx_rssi), .rrx_opt(rrx_opt));
  sfc_link_properties sfc_link_properties_inst (.ref_clk(ref_clk), .reset_n(reset_n),
    .h2d_data(link.h2d_data), .h2d_valid(link.h2d_valid), .h2d_ready(link.h2d_ready),
    .d2h_data(link.d2h_data), .d2h_valid(link.d2h_valid), .d2h_ready(link.d2h_ready));
  // 200 MHz clock
  always #2.5 ref_clk = ~ref_clk;
  // Random radio stalls; hold forces a long one so the buffer must refuse
  always @(negedge ref_clk) rtx_ready <= !hold && ($urandom % 4 != 0);
  // Score each result against the oldest note, and log wire bytes
  always @(posedge ref_clk) begin
    if (link.h2d_valid && link.h2d_ready) hq.push_back(link.h2d_data);
    if (link.d2h_valid && link.d2h_ready) wq.push_back(link.d2h_data);
    if (rtx_valid && rtx_ready) begin
      if (rtx_q.size() == 0) cmp("rtx_spare", '0, '1);
      else begin
        e = rtx_q.pop_front();
        cmp("rtx_data", {8'h0, e[7:0]}, {8'h0, rtx_data});
        if (e[9]) cmp("rtx_last", {15'h0, e[8]}, {15'h0, rtx_last});
      end
    end
    if (r2_valid) begin
      if (r2_q.size() == 0) cmp("r2_spare", '0, '1);
      else cmp("r2_data", {8'h0, r2_q.pop_front()}, {8'h0, r2_data});
    end
    if (rx_valid) begin
      if (rx_q.size() == 0) cmp("rx_spare", '0, '1);
      else cmp("rx_data", {8'h0, rx_q.pop_front()}, {8'h0, rx_data});
    end
    if (rx_end) begin
      if (ok_q.size() == 0) cmp("end_spare", '0, '1);
      else cmp("rx_ok", {15'h0, ok_q.pop_front()}, {15'h0, rx_ok});
    end
  end
  task automatic cmp(input string nm, input logic [15:0] x, input logic [15:0] g);
    check_count++;
    if (g !== x) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, x, g);
    end
  endtask : cmp
  task automatic final_report();
    if (n_fail == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report
  task automatic bail(input string nm);
    cmp(nm, '0, '1);
    final_report();
  endtask : bail
  task automatic pace(input int w);
    int k;
    for (k = 0; k < 500 && (w == 0 ? tx_ready : w == 1 ? rrx_ready : link2.h2d_ready) !== 1'b1;
         k++) @(negedge ref_clk);
    if (k >= 500) bail("ready_wait");
    @(negedge ref_clk);
  endtask : pace
  task automatic host_send(input logic [7:0] q[$]);
    tx_len = 16'(q.size());
    foreach (q[i]) begin
      tx_data = q[i];
      tx_valid = 1'b1;
      pace(0);
    end
    tx_valid = 1'b0;
  endtask : host_send
  task automatic radio_rx(input logic [7:0] q[$]);
    rrx_len = 16'(q.size());
    foreach (q[i]) begin
      rrx_data = q[i];
      rrx_last = i == q.size() - 1;
      rrx_valid = 1'b1;
      pace(1);
    end
    rrx_valid = 1'b0;
    rrx_last = 1'b0;
  endtask : radio_rx
  task automatic dev2_send(input logic [7:0] q[$]);
    foreach (q[i]) begin
      link2.h2d_data = q[i];
      link2.h2d_valid = 1'b1;
      pace(2);
    end
    link2.h2d_valid = 1'b0;
    link2.h2d_data = ~link2.h2d_data;
  endtask : dev2_send
  task automatic ev(input logic [3:0] v);
    {mstat_valid, radio_txdone, radio_purged, radio_noack} = v;
    @(negedge ref_clk);
    {mstat_valid, radio_txdone, radio_purged, radio_noack} = 4'h0;
  endtask : ev
  task automatic exp_rx(input logic [7:0] q[$], input logic f);
    foreach (q[i]) rx_q.push_back(q[i]);
    if (f) ok_q.push_back(1'b1);
  endtask : exp_rx
  task automatic exp_tx(input logic [7:0] q[$], input logic c);
    foreach (q[i]) rtx_q.push_back({c, c && (i == q.size() - 1), q[i]});
  endtask : exp_tx
  task automatic drain();
    int k;
    for (k = 0; k < 2000 && rtx_q.size() + r2_q.size() + rx_q.size() + ok_q.size() != 0; k++)
      @(negedge ref_clk);
    if (k >= 2000) bail("drain_wait");
    repeat (8) @(negedge ref_clk);
  endtask : drain
  task automatic wire_chk(input logic d, input logic [7:0] q[$]);
    cmp("wire_len", 16'(q.size()), 16'(d ? wq.size() : hq.size()));
    foreach (q[i]) cmp("wire_byte", {8'h0, q[i]}, {8'h0, d ? wq[i] : hq[i]});
  endtask : wire_chk
  // Main sequence: transparent, framed, escaped
  initial begin
    link2.h2d_valid = 1'b0;
    link2.h2d_data = 8'h0;
    link2.d2h_ready = 1'b1;
    void'($urandom(32'h98a8));
    repeat (4) @(negedge ref_clk);
    reset_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    exp_tx('{8'h41, 8'h42, 8'h43}, 1'b0);
    host_send('{8'h41, 8'h42, 8'h43});
    exp_rx('{8'h51, 8'h52}, 1'b0);
    radio_rx('{8'h51, 8'h52});
    ev(4'h4);
    drain();
    mode = 2'h1;
    repeat (6) @(negedge ref_clk);
    exp_tx('{8'ha1, 8'hb2}, 1'b1);
    f = '{8'h01, 8'h05, 8'h12, 8'h34, 8'h04, 8'ha1, 8'hb2};
    host_send(f);
    drain();
    cmp("rtx_dest", 16'h1234, rtx_dest);
    cmp("rtx_opt", 16'h0004, {8'h0, rtx_opt});
    for (int i = 0; i < 3; i++) begin
      exp_rx('{8'h89, 8'h05, st[i]}, 1'b1);
      ev(evv[i]);
      drain();
    end
    wq.delete();
    mstat_code = 8'h42;
    exp_rx('{8'h8a, 8'h42}, 1'b1);
    ev(4'h8);
    drain();
    wire_chk(1'b1, '{8'h7e, 8'h00, 8'h02, 8'h8a, 8'h42, 8'h33});
    exp_rx('{8'h81, 8'h43, 8'h21, 8'h28, 8'h02, 8'h56, 8'h67}, 1'b1);
    radio_rx('{8'h56, 8'h67});
    drain();
    dev2_send({8'h7e, 8'h00, 8'h07, f, 8'h5d});
    r2_q = '{8'ha1, 8'hb2};
    dev2_send({8'h13, 8'h00, 8'h7e, 8'h00, 8'h07, f, 8'h5c});
    drain();
    mode = 2'h2;
    repeat (6) @(negedge ref_clk);
    hq.delete();
    host_send('{8'h23, 8'h11});
    drain();
    wire_chk(1'b0, '{8'h7e, 8'h00, 8'h02, 8'h23, 8'h7d, 8'h31, 8'hcb});
    b = '{8'h01, 8'h09, 8'hab, 8'hcd, 8'h04, 8'h7e, 8'h7d, 8'h11, 8'h13};
    repeat (4) b.push_back(8'($urandom));
    exp_tx(b[5:$], 1'b1);
    hold = 1'b1;
    host_send(b);
    repeat (30) @(negedge ref_clk);
    cmp("rtx_valid", 16'h1, {15'h0, rtx_valid});
    hold = 1'b0;
    drain();
    cmp("rtx_dest", 16'habcd, rtx_dest);
    exp_rx('{8'h89, 8'h09, 8'h00}, 1'b1);
    ev(4'h4);
    drain();
    wq.delete();
    mstat_code = 8'h11;
    exp_rx('{8'h8a, 8'h11}, 1'b1);
    ev(4'h8);
    drain();
    wire_chk(1'b1, '{8'h7e, 8'h00, 8'h02, 8'h8a, 8'h7d, 8'h31, 8'h64});
    {rrx_src, rrx_rssi, rrx_opt} = 32'($urandom);
    exp_rx({8'h81, rrx_src[15:8], rrx_src[7:0], rrx_rssi, rrx_opt, 8'h7e, 8'h13}, 1'b1);
    radio_rx('{8'h7e, 8'h13});
    r2_q = '{8'h11, 8'hb2};
    dev2_send({8'h7e, 8'h00, 8'h07, f[0:4], 8'h7d, 8'h31, 8'hb2, 8'hec});
    drain();
    final_report();
  end
endmodule : serial_api_frame_codec_tb_top
`default_nettype wire
